// *** rtl/atseq_top.sv ***
// Trigger sequencer for a scan acquisition with AHB-Lite register access.
// Assumes scans arrive one word each on AI_* and all pins are synchronous to MCLK.
// Notes on behaviour
// - With pretrigger and total above zero, posttrigger begins only after pretrigger fills.
// - Pretriggered capture runs indefinitely until stop trigger, then finishes posttrigger.
// - Software-start pretrigger capture begins on a host-written go strobe.
// - Start and stop triggers configured separately; go strobe arms a hardware start, which then begins capture.
// - Pretriggered hardware start from digital B or analog; stop from digital A or analog.
// - Pretrigger store keeps only the newest pretrigger-count scans.
// - Type 4 gates the scan clock from the external digital gate input.
// - False gate halts the clock at once; true gate resumes where it stopped.
// - Type 5 gates the scan clock from the analog trigger circuit.
// - Type 6 exposes the analog comparator output as a general signal.
// - Types 1, 5, 6 share one analog circuit; last enabled sets its setup.
// - Enabling type 5 replaces any digital gate setup from type 4.
// - Fixed-source mode takes start and stop from one external trigger pin.
// - With zero pretrigger, types 1 or 2 start capture; digital B is illegal.
`timescale 1ns/1ns
`include "atseq_cfg.svh"
module atseq_top (
  input  wire logic        MCLK,       // 250 MHz clock
  input  wire logic        RST_N,      // Async reset, active low
  input  wire logic        CE,         // Clock enable
  input  wire logic        HSEL,       // Slave select
  input  wire logic [31:0] HADDR,      // Byte address
  input  wire logic [1:0]  HTRANS,     // Transfer type
  input  wire logic        HWRITE,     // Write when high
  input  wire logic [2:0]  HSIZE,      // Word only
  input  wire logic [31:0] HWDATA,     // Write data
  input  wire logic        HREADY,     // Bus ready
  output logic      [31:0] HRDATA,     // Read data, registered
  output logic             HREADYOUT,  // Always ready
  output logic             HRESP,      // Always OKAY
  input  wire logic        AI_VALID,   // Scan word offered
  input  wire logic [15:0] AI_DATA,    // Scan word
  output logic             AI_READY,   // Scan word taken
  output logic             SCAN_CLK_EN,// Scan clock run
  input  wire logic [15:0] SHARED_TRIGGER_INPUT_PIN_ZERO, // Digitised pin zero
  input  wire logic        START_TRIGGER_PIN,   // Digital trigger B
  input  wire logic        STOP_TRIGGER_PIN,    // Digital trigger A
  input  wire logic        EXTERNAL_TRIGGER_PIN,// Fixed-source trigger
  input  wire logic        EXTERNAL_GATE_INPUT, // Digital gate
  output logic             ANALOG_TRIGGER_COMPARATOR_OUTPUT, // Comparator out
  output logic             ACQ_DONE    // Capture finished
);
  // ================================================================
  // Declarations
  atseq_pkg::atseq_state_t   state;
  atseq_pkg::atseq_state_t   next_state;
  atseq_pkg::atseq_src_t     start_src;
  atseq_pkg::atseq_src_t     stop_src;
  atseq_pkg::atseq_gate_t    gate_mode;
  atseq_pkg::atseq_acfg_t    stg_acfg;
  atseq_pkg::atseq_acfg_t    act_acfg;
  atseq_pkg::atseq_ahb_req_t req;
  logic [15:0] total_n;
  logic [4:0]  pre_n;
  logic        fixed_pin;
  logic        atc_en;
  logic [2:0]  ana_owner;
  logic        err;
  logic        done;
  logic        cmp;
  logic        cmp_q;
  logic        pin_a_q;
  logic        pin_b_q;
  logic [15:0] ring [`ATSEQ_RING_DEPTH];
  logic [3:0]  wp;
  logic [3:0]  rp;
  logic [4:0]  pre_cnt;
  logic [4:0]  drain_left;
  logic [15:0] post_left;
  logic [15:0] post_cnt;
  logic        f_in_valid;
  logic        f_in_ready;
  logic [15:0] f_in_data;
  logic        f_out_valid;
  logic [15:0] f_out_data;
  logic [2:0]  f_count;

  // ================================================================
  // Bus decode
  wire        addr_ph  = HSEL & HTRANS[1] & HREADY;
  wire [7:0]  ahb_a    = HADDR[7:0];
  wire        wr_ph    = req.valid & req.write;
  wire        wr_ctrl  = wr_ph & (req.addr == `ATSEQ_A_CTRL);
  wire        wr_total = wr_ph & (req.addr == `ATSEQ_A_TOTAL);
  wire        wr_pre   = wr_ph & (req.addr == `ATSEQ_A_PRE);
  wire        wr_acfg  = wr_ph & (req.addr == `ATSEQ_A_ACFG);
  wire        wr_tsel  = wr_ph & (req.addr == `ATSEQ_A_TSEL);
  wire        wr_stat  = wr_ph & (req.addr == `ATSEQ_A_STAT);
  wire        rd_pop   = addr_ph & ~HWRITE & (ahb_a == `ATSEQ_A_DATA);
  wire        go       = wr_ctrl & HWDATA[`ATSEQ_CTRL_GO];
  wire        abort    = wr_ctrl & HWDATA[`ATSEQ_CTRL_ABORT];

  // TSEL write fields
  wire [2:0]  tt       = HWDATA[2:0];
  wire        t_en     = HWDATA[`ATSEQ_TSEL_EN];
  wire        t_start  = HWDATA[`ATSEQ_TSEL_ROLE];
  wire        pre_z    = (pre_n == 5'h00);
  wire        is_edge  = (tt == `ATSEQ_TT_ANA) | (tt == `ATSEQ_TT_DIGA)
                       | (tt == `ATSEQ_TT_DIGB);
  wire        is_ana_t = (tt == `ATSEQ_TT_ANA) | (tt == `ATSEQ_TT_AGATE)
                       | (tt == `ATSEQ_TT_ATCO);
  wire atseq_pkg::atseq_src_t t_src = (tt == `ATSEQ_TT_ANA)  ? atseq_pkg::SRC_ANA
                                    : (tt == `ATSEQ_TT_DIGA) ? atseq_pkg::SRC_DIGA
                                    : atseq_pkg::SRC_DIGB;
  // Slot choice: start when posttriggered or when host asks for start role
  wire        to_start = pre_z | t_start;
  // Digital B never starts a posttrigger run; pretriggered start excludes A, stop excludes B
  wire        t_bad    = is_edge & t_en & (to_start
                         ? (pre_z ? (tt == `ATSEQ_TT_DIGB)
                                  : (tt == `ATSEQ_TT_DIGA))
                         : (tt == `ATSEQ_TT_DIGB));
  wire        t_ok     = wr_tsel & ~t_bad;

  // ================================================================
  // Trigger pins and events
  wire pin_a = fixed_pin ? EXTERNAL_TRIGGER_PIN : STOP_TRIGGER_PIN;
  wire pin_b = fixed_pin ? EXTERNAL_TRIGGER_PIN : START_TRIGGER_PIN;
  wire evt_a   = pin_a & ~pin_a_q;
  wire evt_b   = pin_b & ~pin_b_q;
  wire evt_ana = cmp & ~cmp_q;
  wire start_evt = (start_src == atseq_pkg::SRC_ANA  & evt_ana)
                 | (start_src == atseq_pkg::SRC_DIGA & evt_a)
                 | (start_src == atseq_pkg::SRC_DIGB & evt_b);
  wire stop_evt  = (stop_src == atseq_pkg::SRC_ANA  & evt_ana)
                 | (stop_src == atseq_pkg::SRC_DIGA & evt_a);

  // ================================================================
  // Scan clock gating and data path
  wire gate_ok = (gate_mode == atseq_pkg::GATE_DIG) ? EXTERNAL_GATE_INPUT
               : (gate_mode == atseq_pkg::GATE_ANA) ? cmp
               : 1'b1;
  wire in_pre   = (state == atseq_pkg::ST_PRE);
  wire in_post  = (state == atseq_pkg::ST_POST);
  wire in_drain = (state == atseq_pkg::ST_DRAIN);
  // Combinational so a false gate stops the very next scan word
  assign SCAN_CLK_EN = (in_pre | in_post) & gate_ok;
  assign AI_READY    = SCAN_CLK_EN & (in_pre | f_in_ready);
  wire   scan_take   = AI_VALID & AI_READY;
  assign f_in_valid  = in_drain | (in_post & AI_VALID & SCAN_CLK_EN);
  assign f_in_data   = in_drain ? ring[rp] : AI_DATA;
  wire   f_push      = f_in_valid & f_in_ready;
  wire   pre_full    = (pre_cnt == pre_n);
  wire [15:0] pre_w  = {11'h000, pre_n};
  wire [15:0] post_n = (total_n > pre_w) ? total_n - pre_w : 16'h0000;
  wire   cont        = (total_n == 16'h0000);
  wire [3:0] ring_top = 4'(pre_n - 5'h01);

  // Analog comparator input: pin zero every cycle, or channel on each scan
  wire [15:0] a_val  = act_acfg.from_chan ? AI_DATA : SHARED_TRIGGER_INPUT_PIN_ZERO;
  wire        a_upd  = ~act_acfg.from_chan | scan_take;
  wire        a_hit  = act_acfg.below ? (a_val < act_acfg.level)
                                      : (a_val > act_acfg.level);

  // ================================================================
  // Next state
  always_comb begin
    next_state = state;
    case (state)
      atseq_pkg::ST_IDLE, atseq_pkg::ST_DONE: begin
        if (go) begin
          if (start_src != atseq_pkg::SRC_NONE) begin
            next_state = atseq_pkg::ST_WSTART;
          end else if (pre_z) begin
            next_state = atseq_pkg::ST_POST;
          end else begin
            next_state = atseq_pkg::ST_PRE;
          end
        end
      end
      atseq_pkg::ST_WSTART: begin
        if (start_evt) begin
          next_state = pre_z ? atseq_pkg::ST_POST : atseq_pkg::ST_PRE;
        end
      end
      atseq_pkg::ST_PRE: begin
        // Stop trigger honoured only once the pretrigger store is full
        if (pre_full && stop_evt) begin
          next_state = atseq_pkg::ST_DRAIN;
        end
      end
      atseq_pkg::ST_DRAIN: begin
        if (f_push && drain_left == 5'h01) begin
          next_state = (post_n == 16'h0000) ? atseq_pkg::ST_DONE : atseq_pkg::ST_POST;
        end
      end
      atseq_pkg::ST_POST: begin
        if (f_push && !cont && post_left == 16'h0001) begin
          next_state = atseq_pkg::ST_DONE;
        end
      end
      default: next_state = atseq_pkg::ST_IDLE;
    endcase
    if (abort) begin
      next_state = atseq_pkg::ST_IDLE;
    end
  end

  // ================================================================
  // State register
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= atseq_pkg::ST_IDLE;
    end else if (CE) begin
      state <= next_state;
    end
  end

  // Pretrigger ring storage; no reset needed for data
  always_ff @(posedge MCLK) begin
    if (CE && in_pre && scan_take) begin
      ring[wp] <= AI_DATA;
    end
  end

  // Ring pointers: write wraps at pretrigger count, oldest overwritten
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      wp      <= 4'h0;
      rp      <= 4'h0;
      pre_cnt <= 5'h00;
    end else if (CE) begin
      if (next_state == atseq_pkg::ST_PRE && !in_pre) begin
        wp      <= 4'h0;
        pre_cnt <= 5'h00;
      end else if (in_pre && scan_take) begin
        wp <= (wp == ring_top) ? 4'h0 : wp + 4'h1;
        if (!pre_full) pre_cnt <= pre_cnt + 5'h01;
      end
      // Oldest kept scan sits at the write pointer once full
      if (next_state == atseq_pkg::ST_DRAIN && in_pre) begin
        rp <= (scan_take && wp != ring_top) ? wp + 4'h1
            : (scan_take ? 4'h0 : wp);
      end else if (in_drain && f_push) begin
        rp <= (rp == ring_top) ? 4'h0 : rp + 4'h1;
      end
    end
  end

  // Drain and posttrigger counters
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      drain_left <= 5'h00;
      post_left  <= 16'h0000;
      post_cnt   <= 16'h0000;
    end else if (CE) begin
      if (next_state == atseq_pkg::ST_DRAIN && in_pre) begin
        drain_left <= pre_n;
        post_left  <= post_n;
        post_cnt   <= 16'h0000;
      end else if (next_state == atseq_pkg::ST_POST && pre_z && !in_post) begin
        post_left  <= total_n;
        post_cnt   <= 16'h0000;
      end else if (in_drain && f_push) begin
        drain_left <= drain_left - 5'h01;
      end else if (in_post && f_push) begin
        post_left  <= post_left - 16'h0001;
        post_cnt   <= post_cnt + 16'h0001;
      end
    end
  end

  // ================================================================
  // Trigger sampling and shared analog comparator
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_a_q <= 1'b0;
      pin_b_q <= 1'b0;
      cmp     <= 1'b0;
      cmp_q   <= 1'b0;
    end else if (CE) begin
      pin_a_q <= pin_a;
      pin_b_q <= pin_b;
      cmp_q   <= cmp;
      if (a_upd) cmp <= a_hit;
    end
  end
  assign ANALOG_TRIGGER_COMPARATOR_OUTPUT = atc_en & cmp;

  // ================================================================
  // Configuration registers
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      total_n   <= `ATSEQ_TOTAL_RST;
      pre_n     <= `ATSEQ_PRE_RST;
      fixed_pin <= 1'b0;
      stg_acfg  <= '0;
    end else if (CE) begin
      if (wr_ctrl)  fixed_pin <= HWDATA[`ATSEQ_CTRL_FIXED];
      if (wr_total) total_n   <= HWDATA[15:0];
      // Ring depth caps the pretrigger count
      if (wr_pre)   pre_n <= (HWDATA[15:0] > 16'h0010) ? `ATSEQ_PRE_MAX : HWDATA[4:0];
      if (wr_acfg)  stg_acfg <= HWDATA[17:0];
    end
  end

  // Trigger type enables; the last analog type enabled loads the circuit
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      start_src <= atseq_pkg::SRC_NONE;
      stop_src  <= atseq_pkg::SRC_NONE;
      gate_mode <= atseq_pkg::GATE_OFF;
      atc_en    <= 1'b0;
      ana_owner <= 3'h0;
      act_acfg  <= '0;
    end else if (CE && t_ok) begin
      if (t_en && is_ana_t) begin
        act_acfg  <= stg_acfg;
        ana_owner <= tt;
      end
      if (is_edge && to_start) start_src <= t_en ? t_src : atseq_pkg::SRC_NONE;
      if (is_edge && !to_start) stop_src <= t_en ? t_src : atseq_pkg::SRC_NONE;
      if (tt == `ATSEQ_TT_DGATE) begin
        gate_mode <= t_en ? atseq_pkg::GATE_DIG : atseq_pkg::GATE_OFF;
      end
      if (tt == `ATSEQ_TT_AGATE) begin
        gate_mode <= t_en ? atseq_pkg::GATE_ANA : atseq_pkg::GATE_OFF;
      end
      if (tt == `ATSEQ_TT_ATCO) atc_en <= t_en;
    end
  end

  // Sticky status; a hardware set beats a same-cycle clear
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      err  <= 1'b0;
      done <= 1'b0;
    end else if (CE) begin
      err  <= (wr_tsel & t_bad)
            | (err & ~(wr_stat & HWDATA[`ATSEQ_STAT_ERR]));
      done <= (next_state == atseq_pkg::ST_DONE & ~(state == atseq_pkg::ST_DONE))
            | (done & ~go & ~(wr_stat & HWDATA[`ATSEQ_STAT_DONE]));
    end
  end
  assign ACQ_DONE = done;

  // ================================================================
  // Captured sample FIFO, drained by DATA reads
  atseq_fifo #(
    .W (`ATSEQ_DATA_W),
    .D (`ATSEQ_FIFO_DEPTH)
  ) u_fifo (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .ce        (CE),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (rd_pop),
    .out_data  (f_out_data),
    .count     (f_count)
  );

  // ================================================================
  // AHB-Lite slave: zero wait states, read data loaded at address phase
  wire [31:0] rd_mux =
      (ahb_a == `ATSEQ_A_CTRL)  ? {29'h0, fixed_pin, 2'b00}
    : (ahb_a == `ATSEQ_A_TOTAL) ? {16'h0, total_n}
    : (ahb_a == `ATSEQ_A_PRE)   ? {27'h0, pre_n}
    : (ahb_a == `ATSEQ_A_ACFG)  ? {14'h0, stg_acfg}
    : (ahb_a == `ATSEQ_A_TSEL)  ? {22'h0, ana_owner, atc_en, 2'(gate_mode),
                                   2'(stop_src), 2'(start_src)}
    : (ahb_a == `ATSEQ_A_STAT)  ? {13'h0, f_count, 2'b00, 6'(state), 5'h00,
                                   err, done, pre_full}
    : (ahb_a == `ATSEQ_A_DATA)  ? {15'h0, f_out_valid, f_out_data}
    : (ahb_a == `ATSEQ_A_COUNT) ? {16'h0, post_cnt}
    : 32'h0000_0000;

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      req    <= '0;
      HRDATA <= 32'h0000_0000;
    end else if (CE) begin
      if (HREADY) req <= '{valid: addr_ph, write: HWRITE, addr: ahb_a};
      if (addr_ph && !HWRITE) HRDATA <= rd_mux;
    end
  end
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
endmodule : atseq_top

// *** shared/atseq_cfg.svh ***
// Register map, field positions, reset values and sizes of the trigger sequencer.
// Assumes a 32-bit AHB-Lite slave decoding the low byte of the address.
`ifndef ATSEQ_CFG_SVH
`define ATSEQ_CFG_SVH
// ==================================================================
// Register byte addresses
`define ATSEQ_A_CTRL    8'h00
`define ATSEQ_A_TOTAL   8'h04
`define ATSEQ_A_PRE     8'h08
`define ATSEQ_A_ACFG    8'h0c
`define ATSEQ_A_TSEL    8'h10
`define ATSEQ_A_STAT    8'h14
`define ATSEQ_A_DATA    8'h18
`define ATSEQ_A_COUNT   8'h1c
// ==================================================================
// CTRL fields
`define ATSEQ_CTRL_GO    0
`define ATSEQ_CTRL_ABORT 1
`define ATSEQ_CTRL_FIXED 2
// TSEL fields
`define ATSEQ_TSEL_EN    3
`define ATSEQ_TSEL_ROLE  4
// STAT fields
`define ATSEQ_STAT_FULL  0
`define ATSEQ_STAT_DONE  1
`define ATSEQ_STAT_ERR   2
// ACFG fields
`define ATSEQ_ACFG_BELOW 16
`define ATSEQ_ACFG_CHAN  17
// ==================================================================
// Trigger type codes
`define ATSEQ_TT_ANA   3'h1
`define ATSEQ_TT_DIGA  3'h2
`define ATSEQ_TT_DIGB  3'h3
`define ATSEQ_TT_DGATE 3'h4
`define ATSEQ_TT_AGATE 3'h5
`define ATSEQ_TT_ATCO  3'h6
// ==================================================================
// Sizes and reset values
`define ATSEQ_RING_DEPTH 16
`define ATSEQ_PRE_MAX    5'h10
`define ATSEQ_FIFO_DEPTH 4
`define ATSEQ_DATA_W     16
`define ATSEQ_TOTAL_RST  16'h0000
`define ATSEQ_PRE_RST    5'h00
`endif

// *** shared/atseq_pkg.sv ***
// Types shared by the trigger sequencer files.
// Assumes atseq_cfg.svh supplies the numeric constants.
package atseq_pkg;
  // ================================================================
  // Sequencer states, one-hot
  typedef enum logic [5:0] {
    ST_IDLE   = 6'b000001,
    ST_WSTART = 6'b000010,
    ST_PRE    = 6'b000100,
    ST_DRAIN  = 6'b001000,
    ST_POST   = 6'b010000,
    ST_DONE   = 6'b100000
  } atseq_state_t;
  // Trigger sources for the start and stop slots
  typedef enum logic [1:0] {
    SRC_NONE = 2'h0,
    SRC_ANA  = 2'h1,
    SRC_DIGA = 2'h2,
    SRC_DIGB = 2'h3
  } atseq_src_t;
  // Scan clock gate modes
  typedef enum logic [1:0] {
    GATE_OFF = 2'h0,
    GATE_DIG = 2'h1,
    GATE_ANA = 2'h2
  } atseq_gate_t;
  // Analog trigger circuit setup
  typedef struct packed {
    logic        from_chan;
    logic        below;
    logic [15:0] level;
  } atseq_acfg_t;
  // Latched AHB address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
  } atseq_ahb_req_t;
endpackage : atseq_pkg

// *** rtl/atseq_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides.
// Assumes one clock; ce low freezes all state.
`timescale 1ns/1ns
module atseq_fifo #(
  parameter int W = 16,
  parameter int D = 4
) (
  input  wire logic                 clk,      // Clock
  input  wire logic                 rst_n,    // Async reset, active low
  input  wire logic                 ce,       // Clock enable
  input  wire logic                 in_valid, // Write request
  output logic                      in_ready, // Not full
  input  wire logic [W-1:0]         in_data,  // Write data
  output logic                      out_valid,// Not empty
  input  wire logic                 out_ready,// Read accept
  output logic [W-1:0]              out_data, // Head word
  output logic [$clog2(D):0]        count     // Fill level
);
  localparam int AW = $clog2(D);
  logic [W-1:0]  mem [D];
  logic [AW-1:0] wp;
  logic [AW-1:0] rp;
  wire push = in_valid & in_ready;
  wire pop  = out_valid & out_ready;

  // ================================================================
  // Flags; full refuses writes so the source stalls
  assign in_ready  = (count != ($clog2(D)+1)'(D));
  assign out_valid = (count != '0);
  assign out_data  = mem[rp];

  // Storage, not reset on purpose
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem[wp] <= in_data;
    end
  end

  // Pointers and level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp    <= '0;
      rp    <= '0;
      count <= '0;
    end else if (ce) begin
      if (push) wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
      if (pop)  rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : atseq_fifo

// *** dv/atseq_monitor.sv ***
// Port checker of atseq_top, bound at the foot.
// Assumes one clock MCLK and async reset RST_N.
`timescale 1ns/1ns
module atseq_monitor (
  input wire logic        MCLK, RST_N, CE, HSEL, HWRITE, HREADY, HREADYOUT, // Clock, bus
  input wire logic [1:0]  HTRANS,                                          // Transfer
  input wire logic [31:0] HRDATA,                                          // Read data
  input wire logic        AI_READY, SCAN_CLK_EN, ACQ_DONE                  // Status
);
  // ==================================================================
  // Bus phase tracking
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  wire  ap = HSEL && HTRANS[1] && HREADY && CE; // Address phase taken
  logic wr_dp;                                  // Write in data phase
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) wr_dp <= 1'b0;
    else if (CE) wr_dp <= ap && HWRITE;
  end
  // Done is only cleared by a host write, never by itself
  sequence s_done; $rose(ACQ_DONE); endsequence
  property p_rdy; HREADYOUT; endproperty
  property p_rst; $rose(RST_N) |-> !ACQ_DONE && !AI_READY && !SCAN_CLK_EN; endproperty
  property p_rd0; $rose(RST_N) |-> HRDATA == 32'h0; endproperty
  property p_hold; !(ap && !HWRITE) |=> $stable(HRDATA); endproperty
  property p_frz; !CE |=> $stable(ACQ_DONE); endproperty
  property p_take; AI_READY |-> SCAN_CLK_EN; endproperty
  property p_done; s_done |-> !SCAN_CLK_EN && !AI_READY; endproperty
  property p_clr; $fell(ACQ_DONE) |-> $past(wr_dp); endproperty
  a_rdy: assert property (p_rdy) else $error("slave not ready");
  a_rst: assert property (p_rst) else $error("not idle after reset");
  a_rd0: assert property (p_rd0) else $error("read data not clear after reset");
  a_hold: assert property (p_hold) else $error("read data moved");
  a_frz: assert property (p_frz) else $error("done moved while frozen");
  a_take: assert property (p_take) else $error("word taken while paused");
  a_done: assert property (p_done) else $error("scan runs after done");
  a_clr: assert property (p_clr) else $error("done cleared without write");
endmodule : atseq_monitor
bind atseq_top atseq_monitor u_atseq_monitor (.MCLK, .RST_N, .CE, .HSEL, .HWRITE, .HREADY,
  .HREADYOUT, .HTRANS, .HRDATA, .AI_READY, .SCAN_CLK_EN, .ACQ_DONE);

// *** dv/atseq_ai_model.sv ***
// Scan word source facing the AI side of atseq_top.
// Assumes pause is a fresh random bit each cycle.
`timescale 1ns/1ns
module atseq_ai_model (
  input wire logic        clk, rst_n, ce, pause, ready, // Clock, reset, enable, stall, take
  output logic            valid,                        // Word offered
  output logic [15:0]     data                          // Word
);
  // ==================================================================
  // Offer held until taken; words count up so order shows
  logic [15:0] cnt;
  assign data = valid ? cnt : ~cnt; // No stale word while idle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) {valid, cnt} <= 17'h0;
    else begin
      valid <= (valid && !(ready && ce)) || !pause;
      cnt   <= cnt + {15'h0, valid && ready && ce};
    end
  end
endmodule : atseq_ai_model

// *** dv/tb_top.sv ***
// Bench of atseq_top: AHB-Lite tasks, scan word source, trigger pins.
// Assumes design, checker and word source compile first.
`timescale 1ns/1ns
module tb_top;
  logic        mclk = 1'b0, rst_n = 1'b0, ce = 1'b1, gate = 1'b1, stop = 1'b0, hsel = 1'b0;
  logic        hwrite = 1'b0, hrdy, vld, rdy, clk_en, atco, done, hresp;
  logic [1:0]  htrans = 2'h0;
  logic [15:0] pin0 = 16'h0, ai, w0, lvl, wgo;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'hfa3ee749;
  logic [31:0] texp [3] = '{32'h010, 32'h2a0, 32'h360};
  int          miscompares = 0, n_tests = 0, k;
  // ==================================================================
  // Helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] post_cnt(input logic [31:0] tot, input logic [31:0] pre);
    return tot - pre;
  endfunction : post_cnt
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One single word transfer; waits on the slave, never on a fixed count
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge mclk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge mclk); while (hrdy !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask : bus
  task automatic summarize;
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // Clock and a random bit stream that also stalls the word source
  always #2 mclk = ~mclk;
  always @(posedge mclk) seed <= lfsr(seed);
  atseq_top u_atseq_top (.MCLK(mclk), .RST_N(rst_n), .CE(ce), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hrdy),
    .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .AI_VALID(vld), .AI_DATA(ai),
    .AI_READY(rdy), .SCAN_CLK_EN(clk_en), .SHARED_TRIGGER_INPUT_PIN_ZERO(pin0),
    .START_TRIGGER_PIN(1'b0), .STOP_TRIGGER_PIN(stop), .EXTERNAL_TRIGGER_PIN(1'b0),
    .EXTERNAL_GATE_INPUT(gate), .ANALOG_TRIGGER_COMPARATOR_OUTPUT(atco), .ACQ_DONE(done));
  atseq_ai_model u_atseq_ai_model (.clk(mclk), .rst_n(rst_n), .ce(ce), .pause(seed[0]),
    .ready(rdy), .valid(vld), .data(ai));
  // Main sequence
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0, rd);
    bus(1'b1, 8'h10, 32'h1b);
    bus(1'b0, 8'h14, 32'h0);
    chk("stat", 32'h105, rd & 32'h3f07);
    bus(1'b1, 8'h14, 32'h4);
    for (k = 0; k < 3; k++) begin
      bus(1'b1, 8'h10, 32'h0c + k);
      bus(1'b0, 8'h10, 32'h0);
      chk("tsel", texp[k], rd & 32'h3ff);
    end
    lvl = {1'b0, seed[14:0]} + 16'h1;
    bus(1'b1, 8'h0c, {16'h0, lvl}); // Pin zero source
    bus(1'b1, 8'h10, 32'h0e);
    for (k = 1; k >= 0; k--) begin
      pin0 <= k ? lvl + 16'h1 : lvl - 16'h1;
      repeat (4) @(posedge mclk);
      chk("cmp", k, {31'h0, atco});
    end
    bus(1'b1, 8'h10, 32'h0c);
    bus(1'b1, 8'h00, 32'h1);
    for (k = 0; k < 2; k++) begin
      gate <= k[0];
      repeat (2) @(posedge mclk);
      chk("gate", k, {31'h0, clk_en});
    end
    ce <= 1'b0;
    repeat (3) @(posedge mclk);
    ce <= 1'b1;
    bus(1'b1, 8'h00, 32'h2);
    do bus(1'b0, 8'h18, 32'h0); while (rd[16]);
    bus(1'b1, 8'h08, 32'h2);
    bus(1'b1, 8'h04, 32'h5);
    bus(1'b1, 8'h10, 32'h0a);
    bus(1'b1, 8'h00, 32'h1);
    wgo = u_atseq_ai_model.cnt;
    repeat (30) @(posedge mclk);
    bus(1'b0, 8'h14, 32'h0);
    chk("pre", 32'h0401, rd & 32'h3f01);
    stop <= 1'b1;
    repeat (3) @(posedge mclk);
    stop <= 1'b0;
    for (k = 0; k < 5; k++) begin
      do bus(1'b0, 8'h18, 32'h0); while (!rd[16]);
      if (k == 0) w0 = rd[15:0];
      chk("word", {16'h1, w0 + k[15:0]}, rd & 32'h1ffff);
    end
    chk("old", 32'h1, {31'h0, w0 > wgo});
    bus(1'b0, 8'h1c, 32'h0);
    chk("count", post_cnt(32'h5, 32'h2), rd);
    bus(1'b0, 8'h14, 32'h0);
    chk("done", 32'h2002, rd & 32'h3f02);
    chk("acq_done", 32'h1, {31'h0, done});
    bus(1'b1, 8'h14, 32'h2);
    @(posedge mclk);
    chk("acq_clr", 32'h0, {31'h0, done});
    summarize();
  end
  // Watchdog well beyond the expected run
  initial begin
    repeat (5000) @(posedge mclk);
    miscompares++;
    summarize();
  end
endmodule : tb_top
